// file: uart_mp_pkg.sv
// constants shared by the serial transceiver files
package uart_mp_pkg;
	// ------------------------------------------------------------
	// baud generation
	// ------------------------------------------------------------
	localparam int BAUD_DIV_WIDTH = 12;
	localparam int BAUD_DIV_MAX = 4095;
	localparam int OVERSAMPLE = 16;
	localparam logic [3:0] OVERSAMPLE_LAST = 4'(OVERSAMPLE - 1);

	// ------------------------------------------------------------
	// receive sample positions (count 0 is sample 1)
	// ------------------------------------------------------------
	localparam logic [3:0] VOTE_FIRST = 4'h7;
	localparam logic [3:0] VOTE_SECOND = 4'h8;
	localparam logic [3:0] VOTE_LAST = 4'h9;

	// ------------------------------------------------------------
	// character framing
	// ------------------------------------------------------------
	localparam int DATA_BITS = 8;
	localparam logic [3:0] FRAME_BITS_8 = 4'hA;
	localparam logic [3:0] FRAME_BITS_9 = 4'hB;
	localparam logic [3:0] STOP_IDX_8 = 4'h8;
	localparam logic [3:0] STOP_IDX_9 = 4'h9;
	localparam int TX_SHIFT_WIDTH = 11;
	localparam int RX_SHIFT_WIDTH = 10;
	localparam int NINTH_POS = 8;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic RST_TX_EMPTY = 1'b1;
	localparam logic RST_RX_NINTH = 1'b1;
	localparam logic RST_LINE_IDLE = 1'b1;
	localparam logic [7:0] RST_DATA = 8'h00;

	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} rx_state_e;
endpackage : uart_mp_pkg

// file: uart_baud_gen.sv
// baud divider giving the oversample tick and the bit tick
`timescale 1ns/10ps
module uart_baud_gen #(
	parameter int DIV_WIDTH = uart_mp_pkg::BAUD_DIV_WIDTH
) (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic [DIV_WIDTH-1:0] i_baud_divider,
	output logic o_sample_tick,
	output logic o_bit_tick
);
	logic [DIV_WIDTH-1:0] div_count;
	logic [3:0] prescale;

	initial begin
		if (DIV_WIDTH < 1 || DIV_WIDTH > 16) $error("baud divider width out of range");
	end

	// rate = clock / (16 * (divider + 1))
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			div_count <= '0;
			o_sample_tick <= 1'b0;
		end else if (div_count >= i_baud_divider) begin
			div_count <= '0;
			o_sample_tick <= 1'b1;
		end else begin
			div_count <= div_count + 1'b1;
			o_sample_tick <= 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			prescale <= '0;
			o_bit_tick <= 1'b0;
		end else begin
			o_bit_tick <= 1'b0;
			if (o_sample_tick) begin
				prescale <= prescale + 1'b1;
				o_bit_tick <= (prescale == uart_mp_pkg::OVERSAMPLE_LAST);
			end
		end
	end
endmodule : uart_baud_gen

// file: uart_multiproc_transceiver.sv
// full-duplex serial transceiver with multi-processor address filter
// What this block does
// R1: write with transmitter idle loads the shift register at once.
// R2: write during a character loads after that stop bit completes.
// R3: moving a character into the shift register sets buffer-empty.
// R4: shift register is 11 bits, loaded with a 10- or 11-bit frame, start low, stop high.
// R5: nine-bit mode copies the ninth transmit bit into position 9.
// R6: after load, start bit then data LSB first then stop bit.
// R7: buffer-empty stays set until software writes the data register.
// R8: stop bit held one bit time with nothing pending sets transmit-complete.
// R9: transmitter enable takes the transmit pin as output.
// R10: receive oversamples 16x; one low idle sample starts detection.
// R11: start rejected if two of samples 8, 9, 10 high.
// R12: each data bit is majority of samples 8, 9, 10.
// R13: stop bit majority low sets framing error.
// R14: every finished character not ignored and not overrun moves to receive data and sets receive-complete.
// R15: data address reads receive data and writes transmit data.
// R16: nine-bit mode loads received ninth bit into its read-only field.
// R17: unread previous character discards new one; overrun shown after read.
// R18: receiver enable forces the receive pin to input; pull-up stays.
// R19: nine-bit select gives nine data bits, else eight.
// R20: master sends address with ninth bit one, data with zero.
// R21: address flag is stop bit in 8-bit mode, ninth bit in 9-bit.
// R22: multi-processor mode ignores data bytes, flags untouched.
// R23: buffer-empty is set during reset.
// R24: transmit-complete clears on vector taken or written one.
// R25: reading receive data clears receive-complete.
// R26: baud equals clock over 16 times divider plus one.
`timescale 1ns/10ps
module uart_multiproc_transceiver (
	input wire logic i_ref_clk,
	input wire logic i_rstn,
	input wire logic [11:0] i_baud_divider,
	input wire logic i_transmitter_enable,
	input wire logic i_receiver_enable,
	input wire logic i_nine_bit_select,
	input wire logic i_multiproc_mode,
	input wire logic i_tx_ninth_bit,
	input wire logic i_data_wr,
	input wire logic [7:0] i_data_wdata,
	input wire logic i_data_rd,
	input wire logic i_tx_complete_clear,
	input wire logic i_tx_complete_ack,
	input wire logic i_port_d_line_zero,
	input wire logic i_line_zero_direction,
	input wire logic i_line_zero_output_bit,
	input wire logic i_line_one_direction,
	input wire logic i_line_one_output_bit,
	output logic [7:0] o_serial_data_reg,
	output logic o_rx_ninth_bit,
	output logic o_rx_complete_flag,
	output logic o_tx_complete_flag,
	output logic o_tx_buffer_empty_flag,
	output logic o_framing_error_flag,
	output logic o_overrun_flag,
	output logic o_port_d_line_one,
	output logic o_port_d_line_one_oe,
	output logic o_port_d_line_zero_oe,
	output logic o_line_zero_pullup
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic sample_tick;
	logic bit_tick;
	logic [7:0] tx_data;
	logic tx_data_ninth;
	logic [uart_mp_pkg::TX_SHIFT_WIDTH-1:0] tx_shift;
	logic [3:0] tx_count;
	logic tx_busy;
	logic tx_drain;
	logic tx_line;
	logic tx_load;
	logic tx_end;
	logic rx_meta;
	logic rx_sync;
	uart_mp_pkg::rx_state_e rx_state;
	logic [3:0] rx_phase;
	logic [3:0] rx_index;
	logic [1:0] rx_votes;
	logic [uart_mp_pkg::RX_SHIFT_WIDTH-1:0] rx_shift;
	logic rx_vote_now;
	logic rx_bit;
	logic rx_frame_done;
	logic rx_addr_bit;
	logic rx_ignore;
	logic rx_overrun;
	logic rx_accept;
	logic overrun_pending;

	function automatic logic majority3(input logic a, input logic b, input logic c);
		majority3 = (a & b) | (a & c) | (b & c);
	endfunction : majority3

	// ------------------------------------------------------------
	// baud generation
	// ------------------------------------------------------------
	uart_baud_gen #(
		.DIV_WIDTH(uart_mp_pkg::BAUD_DIV_WIDTH)
	) u_baud (
		.i_ref_clk(i_ref_clk),
		.i_rstn(i_rstn),
		.i_baud_divider(i_baud_divider), // [R26]
		.o_sample_tick(sample_tick),
		.o_bit_tick(bit_tick)
	);

	// ------------------------------------------------------------
	// transmit holding register
	// ------------------------------------------------------------
	// load needs an idle shifter; drain lets a queued character go after disable
	assign tx_load = !o_tx_buffer_empty_flag && !tx_busy
		&& (i_transmitter_enable || tx_drain); // [R1] [R2]
	assign tx_end = tx_busy && bit_tick && (tx_count == 4'h0);

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_data <= uart_mp_pkg::RST_DATA;
			tx_data_ninth <= 1'b0;
		end else if (i_data_wr) begin
			tx_data <= i_data_wdata; // [R15]
			tx_data_ninth <= i_tx_ninth_bit;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_tx_buffer_empty_flag <= uart_mp_pkg::RST_TX_EMPTY; // [R23]
		end else if (i_data_wr) begin
			o_tx_buffer_empty_flag <= 1'b0;
		end else if (tx_load) begin
			o_tx_buffer_empty_flag <= 1'b1; // [R3] [R7]
		end
	end

	// ------------------------------------------------------------
	// transmit shifter
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_shift <= '1;
			tx_count <= 4'h0;
			tx_busy <= 1'b0;
			tx_line <= uart_mp_pkg::RST_LINE_IDLE;
		end else if (tx_load) begin
			tx_busy <= 1'b1;
			if (i_nine_bit_select) begin // [R19]
				tx_shift <= {1'b1, tx_data_ninth, tx_data, 1'b0}; // [R4] [R5]
				tx_count <= uart_mp_pkg::FRAME_BITS_9;
			end else begin
				tx_shift <= {2'b11, tx_data, 1'b0}; // [R4]
				tx_count <= uart_mp_pkg::FRAME_BITS_8;
			end
		end else if (tx_busy && bit_tick) begin
			if (tx_count == 4'h0) begin
				tx_busy <= 1'b0;
			end else begin
				tx_line <= tx_shift[0]; // [R6]
				tx_shift <= {1'b1, tx_shift[uart_mp_pkg::TX_SHIFT_WIDTH-1:1]};
				tx_count <= tx_count - 1'b1;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_drain <= 1'b0;
		end else begin
			tx_drain <= tx_busy;
		end
	end

	// set wins over either clear
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_tx_complete_flag <= 1'b0;
		end else if (tx_end && o_tx_buffer_empty_flag && !i_data_wr) begin
			o_tx_complete_flag <= 1'b1; // [R8]
		end else if (i_tx_complete_clear || i_tx_complete_ack) begin
			o_tx_complete_flag <= 1'b0; // [R24]
		end
	end

	// ------------------------------------------------------------
	// pin takeover
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_port_d_line_one <= 1'b0;
			o_port_d_line_one_oe <= 1'b0;
		end else if (i_transmitter_enable || tx_busy) begin
			o_port_d_line_one <= tx_line; // [R9]
			o_port_d_line_one_oe <= 1'b1;
		end else begin
			o_port_d_line_one <= i_line_one_output_bit;
			o_port_d_line_one_oe <= i_line_one_direction;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_port_d_line_zero_oe <= 1'b0;
			o_line_zero_pullup <= 1'b0;
		end else if (i_receiver_enable) begin
			o_port_d_line_zero_oe <= 1'b0; // [R18]
			o_line_zero_pullup <= i_line_zero_output_bit;
		end else begin
			o_port_d_line_zero_oe <= i_line_zero_direction;
			o_line_zero_pullup <= i_line_zero_output_bit & ~i_line_zero_direction;
		end
	end

	// ------------------------------------------------------------
	// receive pin synchroniser
	// ------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_meta <= uart_mp_pkg::RST_LINE_IDLE;
			rx_sync <= uart_mp_pkg::RST_LINE_IDLE;
		end else begin
			rx_meta <= i_port_d_line_zero;
			rx_sync <= rx_meta;
		end
	end

	// ------------------------------------------------------------
	// receive sampler
	// ------------------------------------------------------------
	assign rx_vote_now = sample_tick && (rx_phase == uart_mp_pkg::VOTE_LAST);
	assign rx_bit = majority3(rx_votes[1], rx_votes[0], rx_sync); // [R12]
	assign rx_frame_done = rx_state == uart_mp_pkg::RX_DATA && rx_vote_now
		&& rx_index == (i_nine_bit_select ? uart_mp_pkg::STOP_IDX_9
		: uart_mp_pkg::STOP_IDX_8);

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_state <= uart_mp_pkg::RX_IDLE;
			rx_phase <= 4'h0;
			rx_index <= 4'h0;
		end else if (!i_receiver_enable) begin
			rx_state <= uart_mp_pkg::RX_IDLE;
		end else if (sample_tick) begin
			rx_phase <= rx_phase + 1'b1;
			unique case (rx_state)
				uart_mp_pkg::RX_IDLE: begin
					rx_phase <= 4'h1;
					if (!rx_sync) begin
						rx_state <= uart_mp_pkg::RX_START; // [R10]
					end
				end
				uart_mp_pkg::RX_START: begin
					rx_index <= 4'h0;
					if (rx_phase == uart_mp_pkg::VOTE_LAST && rx_bit) begin
						rx_state <= uart_mp_pkg::RX_IDLE; // [R11]
					end else if (rx_phase == uart_mp_pkg::OVERSAMPLE_LAST) begin
						rx_state <= uart_mp_pkg::RX_DATA;
					end
				end
				uart_mp_pkg::RX_DATA: begin
					if (rx_frame_done) begin
						rx_state <= uart_mp_pkg::RX_IDLE;
					end else if (rx_phase == uart_mp_pkg::OVERSAMPLE_LAST) begin
						rx_index <= rx_index + 1'b1;
					end
				end
				default: begin
					rx_state <= uart_mp_pkg::RX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_votes <= 2'b11;
		end else if (sample_tick) begin
			if (rx_phase == uart_mp_pkg::VOTE_FIRST) begin
				rx_votes[1] <= rx_sync;
			end
			if (rx_phase == uart_mp_pkg::VOTE_SECOND) begin
				rx_votes[0] <= rx_sync;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rx_shift <= '0;
		end else if (rx_state == uart_mp_pkg::RX_DATA && rx_vote_now) begin
			rx_shift[rx_index] <= rx_bit; // [R12]
		end
	end

	// ------------------------------------------------------------
	// receive completion
	// ------------------------------------------------------------
	assign rx_addr_bit = i_nine_bit_select ? rx_shift[uart_mp_pkg::NINTH_POS] : rx_bit; // [R21]
	assign rx_ignore = i_multiproc_mode && !rx_addr_bit; // [R22]
	assign rx_overrun = rx_frame_done && !rx_ignore && o_rx_complete_flag && !i_data_rd;
	assign rx_accept = rx_frame_done && !rx_ignore && !rx_overrun;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_serial_data_reg <= uart_mp_pkg::RST_DATA;
			o_rx_ninth_bit <= uart_mp_pkg::RST_RX_NINTH;
			o_framing_error_flag <= 1'b0;
		end else if (rx_accept) begin
			o_serial_data_reg <= rx_shift[uart_mp_pkg::DATA_BITS-1:0]; // [R14] [R15]
			o_framing_error_flag <= !rx_bit; // [R13]
			if (i_nine_bit_select) begin
				o_rx_ninth_bit <= rx_shift[uart_mp_pkg::NINTH_POS]; // [R16]
			end
		end
	end

	// set wins over the read clear
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rx_complete_flag <= 1'b0;
		end else if (rx_accept) begin
			o_rx_complete_flag <= 1'b1; // [R14]
		end else if (i_data_rd) begin
			o_rx_complete_flag <= 1'b0; // [R25]
		end
	end

	// overrun held back until the good byte is read
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			overrun_pending <= 1'b0;
			o_overrun_flag <= 1'b0;
		end else if (rx_overrun) begin
			overrun_pending <= 1'b1; // [R17]
		end else if (rx_accept) begin
			overrun_pending <= 1'b0;
			o_overrun_flag <= 1'b0;
		end else if (i_data_rd) begin
			o_overrun_flag <= overrun_pending; // [R17]
			overrun_pending <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);

	property p_load_idle;
		!tx_busy && !o_tx_buffer_empty_flag && i_transmitter_enable |=> tx_busy;
	endproperty
	a_load_idle: assert property (p_load_idle) else $error("idle load missed"); // [R1]

	property p_defer;
		tx_busy && !tx_end |=> !$rose(tx_busy) && tx_busy;
	endproperty
	a_defer: assert property (p_defer) else $error("load during character"); // [R2]

	property p_empty_on_load;
		$rose(tx_busy) && !$past(i_data_wr) |-> o_tx_buffer_empty_flag;
	endproperty
	a_empty_on_load: assert property (p_empty_on_load) else $error("empty not set"); // [R3]

	property p_frame;
		tx_load |=> !tx_shift[0] && tx_shift[i_nine_bit_select ? 10 : 9];
	endproperty
	a_frame: assert property (p_frame) else $error("start or stop bit wrong"); // [R4]

	property p_shift_out;
		tx_busy && bit_tick && tx_count != 4'h0 |=> tx_line == $past(tx_shift[0]);
	endproperty
	a_shift_out: assert property (p_shift_out) else $error("bit not shifted"); // [R6]

	property p_empty_holds;
		o_tx_buffer_empty_flag && !i_data_wr |=> o_tx_buffer_empty_flag;
	endproperty
	a_empty_holds: assert property (p_empty_holds) else $error("empty dropped"); // [R7]

	property p_txc_cause;
		$rose(o_tx_complete_flag) |-> $past(tx_end);
	endproperty
	a_txc_cause: assert property (p_txc_cause) else $error("complete without end"); // [R8]

	property p_tx_pin;
		i_transmitter_enable |=> o_port_d_line_one_oe;
	endproperty
	a_tx_pin: assert property (p_tx_pin) else $error("tx pin not driven"); // [R9]

	property p_rx_pin;
		i_receiver_enable |=> !o_port_d_line_zero_oe;
	endproperty
	a_rx_pin: assert property (p_rx_pin) else $error("rx pin driven"); // [R18]

	property p_noise;
		rx_state == uart_mp_pkg::RX_START && rx_vote_now && rx_bit && i_receiver_enable
		|=> rx_state == uart_mp_pkg::RX_IDLE;
	endproperty
	a_noise: assert property (p_noise) else $error("noise start kept"); // [R11]

	property p_overrun_keep;
		rx_overrun |=> $stable(o_serial_data_reg) && o_rx_complete_flag;
	endproperty
	a_overrun_keep: assert property (p_overrun_keep) else $error("overrun overwrote"); // [R17]

	property p_ignore;
		rx_frame_done && rx_ignore && !i_data_rd |=> $stable(o_rx_complete_flag)
		&& $stable(o_framing_error_flag) && $stable(o_serial_data_reg);
	endproperty
	a_ignore: assert property (p_ignore) else $error("data byte not ignored"); // [R22]

	property p_read_clear;
		i_data_rd && !rx_accept |=> !o_rx_complete_flag;
	endproperty
	a_read_clear: assert property (p_read_clear) else $error("read did not clear"); // [R25]
endmodule : uart_multiproc_transceiver

// file: uart_far_node.sv
// far-end serial node: sends frames on line zero, decodes line one
`timescale 1ns/10ps
module uart_far_node (
	input wire logic i_ref_clk,
	input wire logic i_line_in,
	input wire logic i_nine,
	output logic o_line_out
);
	// ------------------------------------------------------------
	// sender
	// ------------------------------------------------------------
	localparam int BIT_CLKS = 16;
	logic [9:0] rx_q[$];
	logic [9:0] w;
	initial o_line_out = 1'b1;
	task automatic hold(input logic v, input int n);
		o_line_out = v;
		repeat (n) @(negedge i_ref_clk);
	endtask : hold
	// start, data lsb first, optional ninth bit, stop
	task automatic send(input logic [7:0] d, input logic b9, input logic nine, input logic stp);
		hold(1'b0, BIT_CLKS);
		for (int i = 0; i < 8; i++) hold(d[i], BIT_CLKS);
		if (nine) hold(b9, BIT_CLKS);
		hold(stp, BIT_CLKS);
		o_line_out = 1'b1;
	endtask : send
	// ------------------------------------------------------------
	// receiver: mid-bit sampling, stored as {stop, ninth, data}
	// ------------------------------------------------------------
	always begin
		@(negedge i_line_in);
		repeat (8) @(posedge i_ref_clk);
		w = '0;
		if (i_line_in === 1'b0) begin
			for (int i = 0; i < 8 + i_nine; i++) begin
				repeat (BIT_CLKS) @(posedge i_ref_clk);
				w[i] = i_line_in;
			end
			repeat (BIT_CLKS) @(posedge i_ref_clk);
			w[9] = i_line_in;
			rx_q.push_back(w);
		end
	end
endmodule : uart_far_node

// file: uart_multiproc_transceiver_bench.sv
// self-checking bench for the serial transceiver
`timescale 1ns/10ps
module uart_multiproc_transceiver_bench;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic te, re, nine, mpm, txb9, wr, rd, tcc, tca, dir0, out0, dir1, out1;
	logic [7:0] wd;
	logic [7:0] rdata;
	logic rx9, rx_complete_flag, tx_complete_flag, txe, fe, ovr, l1, l1oe, l0oe, pu, rxl;
	wire logic line1;
	int err_total = 0;
	int samples_checked = 0;

	assign line1 = l1oe ? l1 : 1'b1;
	always #50 clk = ~clk;

	uart_far_node i_far (.i_ref_clk(clk), .i_line_in(line1), .i_nine(nine), .o_line_out(rxl));

	uart_multiproc_transceiver i_dut (
		.i_ref_clk(clk), .i_rstn(rstn), .i_baud_divider(12'h000),
		.i_transmitter_enable(te), .i_receiver_enable(re), .i_nine_bit_select(nine),
		.i_multiproc_mode(mpm), .i_tx_ninth_bit(txb9), .i_data_wr(wr), .i_data_wdata(wd),
		.i_data_rd(rd), .i_tx_complete_clear(tcc), .i_tx_complete_ack(tca),
		.i_port_d_line_zero(rxl), .i_line_zero_direction(dir0),
		.i_line_zero_output_bit(out0), .i_line_one_direction(dir1),
		.i_line_one_output_bit(out1), .o_serial_data_reg(rdata), .o_rx_ninth_bit(rx9),
		.o_rx_complete_flag(rx_complete_flag), .o_tx_complete_flag(tx_complete_flag), .o_tx_buffer_empty_flag(txe),
		.o_framing_error_flag(fe), .o_overrun_flag(ovr), .o_port_d_line_one(l1),
		.o_port_d_line_one_oe(l1oe), .o_port_d_line_zero_oe(l0oe), .o_line_zero_pullup(pu)
	);

	// ------------------------------------------------------------
	// access tasks
	// ------------------------------------------------------------
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : check

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : end_of_test

	task automatic wr_data(input logic [7:0] d, input logic b9);
		wr = 1'b1;
		wd = d;
		txb9 = b9;
		@(negedge clk);
		wr = 1'b0;
	endtask : wr_data

	task automatic rd_pulse;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		@(negedge clk);
	endtask : rd_pulse

	task automatic wait_txc;
		int n;
		n = 0;
		while (tx_complete_flag !== 1'b1 && n < 1000) begin
			@(negedge clk);
			n++;
		end
		if (n == 1000) begin
			err_total++;
			$display("BAD t=%0t transmit never completed", $time);
			end_of_test();
		end
	endtask : wait_txc

	// expected word is {rx complete, framing, overrun, ninth, data}
	task automatic rx_case(input logic [7:0] d, input logic b9, input logic stp,
		input logic [11:0] exp);
		i_far.send(d, b9, nine, stp);
		@(negedge clk);
		check({rx_complete_flag, fe, ovr, rx9, rdata}, exp);
	endtask : rx_case

	// ------------------------------------------------------------
	// test sequence
	// ------------------------------------------------------------
	initial begin
		{te, re, nine, mpm, txb9, wr, rd, tcc, tca, dir0, out0, dir1, out1} = '0;
		wd = 8'h00;
		repeat (10) @(negedge clk);
		check({txe, rx9, rx_complete_flag, tx_complete_flag, fe, ovr}, 12'h030);
		check(rdata, 12'h000);
		rstn = 1'b1;
		// pin takeover
		dir1 = 1'b1;
		@(negedge clk);
		check(l1oe, 12'h001);
		dir1 = 1'b0;
		@(negedge clk);
		check(l1oe, 12'h000);
		te = 1'b1;
		re = 1'b1;
		dir0 = 1'b1;
		out0 = 1'b1;
		@(negedge clk);
		check({l1oe, l1, l0oe, pu}, 12'h00D);
		out0 = 1'b0;
		@(negedge clk);
		check({l0oe, pu}, 12'h000);
		$display("test pins done");
		// single 8-bit character
		wr_data(8'hA5, 1'b0);
		check(txe, 12'h000);
		@(negedge clk);
		check(txe, 12'h001);
		wait_txc();
		check(i_far.rx_q.pop_front(), 12'h2A5);
		tcc = 1'b1;
		@(negedge clk);
		tcc = 1'b0;
		@(negedge clk);
		check(tx_complete_flag, 12'h000);
		$display("test tx single done");
		// back-to-back 9-bit characters
		nine = 1'b1;
		wr_data(8'h3C, 1'b1);
		@(negedge clk);
		wr_data(8'hC3, 1'b0);
		repeat (20) @(negedge clk);
		check({txe, tx_complete_flag}, 12'h000);
		wait_txc();
		check(i_far.rx_q.pop_front(), 12'h33C);
		check(i_far.rx_q.pop_front(), 12'h2C3);
		tca = 1'b1;
		@(negedge clk);
		tca = 1'b0;
		@(negedge clk);
		check({tx_complete_flag, txe}, 12'h001);
		$display("test tx queue done");
		// 8-bit reception, framing, overrun, noise
		nine = 1'b0;
		rx_case(8'h5A, 1'b0, 1'b1, 12'h95A);
		rd_pulse();
		check({rx_complete_flag, fe, ovr, rx9, rdata}, 12'h15A);
		rx_case(8'h81, 1'b0, 1'b0, 12'hD81);
		rd_pulse();
		rx_case(8'h11, 1'b0, 1'b1, 12'h911);
		rx_case(8'h22, 1'b0, 1'b1, 12'h911);
		rd_pulse();
		check({rx_complete_flag, fe, ovr, rx9, rdata}, 12'h311);
		rx_case(8'h33, 1'b0, 1'b1, 12'h933);
		rd_pulse();
		i_far.hold(1'b0, 4);
		i_far.hold(1'b1, 200);
		check({rx_complete_flag, fe, ovr, rx9, rdata}, 12'h133);
		$display("test rx 8-bit done");
		// 9-bit reception and multi-processor filtering
		nine = 1'b1;
		rx_case(8'hA7, 1'b0, 1'b1, 12'h8A7);
		rd_pulse();
		rx_case(8'h5C, 1'b1, 1'b1, 12'h95C);
		rd_pulse();
		mpm = 1'b1;
		rx_case(8'h66, 1'b0, 1'b1, 12'h15C);
		rx_case(8'h42, 1'b1, 1'b1, 12'h942);
		rd_pulse();
		nine = 1'b0;
		rx_case(8'h77, 1'b0, 1'b0, 12'h142);
		rx_case(8'h24, 1'b0, 1'b1, 12'h924);
		rd_pulse();
		mpm = 1'b0;
		rx_case(8'h99, 1'b0, 1'b0, 12'hD99);
		rd_pulse();
		$display("test rx multi-processor done");
		end_of_test();
	end
endmodule : uart_multiproc_transceiver_bench
